// ### common/lrs_regs.vh
`ifndef LRS_REGS_VH
`define LRS_REGS_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define LRS_OFS_RSVD_A     8'h4c
`define LRS_OFS_RSVD_B     8'h4d
`define LRS_OFS_IDENT      8'h51
`define LRS_OFS_RSVD_C     8'h52
`define LRS_OFS_RSVD_D     8'h56
`define LRS_OFS_RSVD_E     8'h57
`define LRS_OFS_RSVD_F     8'h58
`define LRS_OFS_RSVD_G     8'h59
`define LRS_OFS_RSVD_H     8'h5a
`define LRS_OFS_RSVD_I     8'h5b
`define LRS_OFS_RSVD_J     8'h5c
`define LRS_OFS_OVERRIDE   8'h5e
`define LRS_OFS_ROUTE      8'h5f
// ****************************************
// reset values
// ****************************************
`define LRS_RST_RSVD_A     8'h00
`define LRS_RST_RSVD_B     8'h00
`define LRS_RST_RSVD_C     8'h00
`define LRS_RST_RSVD_D     8'h10
`define LRS_RST_RSVD_E     8'h64
`define LRS_RST_RSVD_F     8'h21
`define LRS_RST_RSVD_G     8'h00
`define LRS_RST_RSVD_H     8'h54
`define LRS_RST_RSVD_I     8'h54
`define LRS_RST_RSVD_J     8'h00
`define LRS_RST_OVERRIDE   8'h00
`define LRS_RST_ROUTE      8'h00
// arbitrary identification value, not any real part's code
`define LRS_IDENT_VALUE    8'h5a
// ****************************************
// field positions
// ****************************************
`define LRS_OVR_LANE1_BIT  2
`define LRS_OVR_LANE0_BIT  1
`define LRS_OVR_INEN_BIT   0
`define LRS_LANE1_HI       7
`define LRS_LANE1_LO       6
`define LRS_LANE0_HI       5
`define LRS_LANE0_LO       4
`define LRS_INEN_HI        3
`define LRS_INEN_LO        2
// ****************************************
// input-enable mode codes
// ****************************************
`define LRS_INEN_NORMAL    2'h0
`define LRS_INEN_RESERVED  2'h1
`define LRS_INEN_AUTO      2'h2
`define LRS_INEN_DUAL_OUTPUT_DRIVE    2'h3
`endif

// ### verilog/lrs_lane_route.v
`timescale 1ns/10ps
`include "lrs_regs.vh"
// ****************************************
// one lane: decode select and mode to enables
// ****************************************
module lrs_lane_route (
  input  wire [1:0] sel_in,
  input  wire [1:0] mode_in,
  input  wire       rxdet_a_in,
  input  wire       rxdet_b_in,
  output reg        input_a_out,
  output reg        input_b_out,
  output reg        output_a_out,
  output reg        output_b_out,
  output reg        term_a_out,
  output reg        term_b_out
);
  // select code: high bit picks input A, low bit picks output A
  always @* begin
    input_a_out  = sel_in[1];                            // [RULE5] [RULE6]
    input_b_out  = ~sel_in[1];
    output_a_out = sel_in[0];
    output_b_out = ~sel_in[0];
    term_a_out   = 1'b0;
    term_b_out   = 1'b0;
    case (mode_in)
      `LRS_INEN_NORMAL: begin                            // [RULE7]
        term_a_out = sel_in[1];                          // [RULE10]
        term_b_out = ~sel_in[1];
      end
      `LRS_INEN_AUTO: begin                              // [RULE8]
        // selected input enabled only if a far receiver is detected
        input_a_out  = sel_in[1] & rxdet_a_in;
        input_b_out  = ~sel_in[1] & rxdet_b_in;
        term_a_out   = input_a_out;
        term_b_out   = input_b_out;
      end
      `LRS_INEN_DUAL_OUTPUT_DRIVE: begin                            // [RULE9]
        output_a_out = 1'b1;
        output_b_out = 1'b1;
        term_a_out   = sel_in[1];                        // [RULE10]
        term_b_out   = ~sel_in[1];
      end
      default: begin
        // reserved code: treated as normal, behaviour is undefined anyway
        term_a_out = sel_in[1];                          // [RULE11]
        term_b_out = ~sel_in[1];
      end
    endcase
  end
endmodule // lrs_lane_route

// ### verilog/lrs_route_regs.v
`timescale 1ns/10ps
`include "lrs_regs.vh"
// Overview of operation
// RULE1: with override bit 2 set, lane 1 routing comes from the control register, not its pin.
// RULE2: with override bit 1 set, lane 0 routing comes from the control register, not its pin.
// RULE3: with override bit 0 set, input-enable mode comes from the control register, not its pin.
// RULE4: a cleared override bit, the reset state, lets the pin decide that field.
// RULE5: lane 1 code 00 B-in/B-out, 01 B-in/A-out, 10 A-in/B-out, 11 A-in/A-out.
// RULE6: lane 0 uses the same four-code routing as lane 1.
// RULE7: mode 00 is normal operation with fan-out off and selects choosing A or B.
// RULE8: mode 10 is automatic, receiver detect plus selects decide the enables, fan-out off.
// RULE9: mode 11 drives both outputs of each lane while staying normal.
// RULE10: in modes 00 and 11 the selected input stays enabled and terminated.
// RULE11: software must not write mode 01, which is reserved and undefined.
// RULE12: each effective field is the register value if overridden, else the pin, every clock. Outputs update only on clocks with clk_en_in high.
module lrs_route_regs (
  input  wire       core_clk_in,
  input  wire       rst_in,
  input  wire       clk_en_in,
  // register port
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  // four-level pins, already decoded to two bits each
  input  wire [1:0] lane1_route_select_in,
  input  wire [1:0] lane0_route_select_in,
  input  wire [1:0] input_enable_pin_in,
  // receiver detect per lane, per side
  input  wire [1:0] rxdet_a_in,
  input  wire [1:0] rxdet_b_in,
  // routing result, bit index is the lane except dual_output_drive_out and input_enable_mode_out, which hold the fan-out flag and the mode code
  output reg  [1:0] input_a_en_out,
  output reg  [1:0] input_b_en_out,
  output reg  [1:0] output_a_en_out,
  output reg  [1:0] output_b_en_out,
  output reg  [1:0] term_a_en_out,
  output reg  [1:0] term_b_en_out,
  output reg        dual_output_drive_out,
  output reg  [1:0] input_enable_mode_out
);
  // ****************************************
  // register storage
  // ****************************************
  reg  [7:0] pin_override_control;
  reg  [7:0] route_select_control;
  reg  [7:0] reserved_cfg [0:9];
  reg  [3:0] rsvd_idx;
  reg        rsvd_hit;
  reg  [7:0] next_rdata;
  wire [7:0] rsvd_reset [0:9];

  assign rsvd_reset[0] = `LRS_RST_RSVD_A;
  assign rsvd_reset[1] = `LRS_RST_RSVD_B;
  assign rsvd_reset[2] = `LRS_RST_RSVD_C;
  assign rsvd_reset[3] = `LRS_RST_RSVD_D;
  assign rsvd_reset[4] = `LRS_RST_RSVD_E;
  assign rsvd_reset[5] = `LRS_RST_RSVD_F;
  assign rsvd_reset[6] = `LRS_RST_RSVD_G;
  assign rsvd_reset[7] = `LRS_RST_RSVD_H;
  assign rsvd_reset[8] = `LRS_RST_RSVD_I;
  assign rsvd_reset[9] = `LRS_RST_RSVD_J;

  // reserved address decode; they only store, nothing reads them internally
  always @* begin
    rsvd_hit = 1'b1;
    rsvd_idx = 4'h0;
    case (reg_addr_in)
      `LRS_OFS_RSVD_A: rsvd_idx = 4'h0;
      `LRS_OFS_RSVD_B: rsvd_idx = 4'h1;
      `LRS_OFS_RSVD_C: rsvd_idx = 4'h2;
      `LRS_OFS_RSVD_D: rsvd_idx = 4'h3;
      `LRS_OFS_RSVD_E: rsvd_idx = 4'h4;
      `LRS_OFS_RSVD_F: rsvd_idx = 4'h5;
      `LRS_OFS_RSVD_G: rsvd_idx = 4'h6;
      `LRS_OFS_RSVD_H: rsvd_idx = 4'h7;
      `LRS_OFS_RSVD_I: rsvd_idx = 4'h8;
      `LRS_OFS_RSVD_J: rsvd_idx = 4'h9;
      default:         rsvd_hit = 1'b0;
    endcase
  end

  // ****************************************
  // writes
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_rsvd
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          reserved_cfg[gi] <= rsvd_reset[gi];
        end else if (clk_en_in && reg_wr_in && rsvd_hit && rsvd_idx == gi) begin
          reserved_cfg[gi] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // only the documented override bits are kept; upper bits read zero
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_override_control <= `LRS_RST_OVERRIDE;                 // [RULE4]
      route_select_control <= `LRS_RST_ROUTE;
    end else if (clk_en_in && reg_wr_in) begin
      if (reg_addr_in == `LRS_OFS_OVERRIDE) begin
        pin_override_control <= {5'h00, reg_wdata_in[2:0]};
      end
      if (reg_addr_in == `LRS_OFS_ROUTE) begin
        route_select_control <= {reg_wdata_in[7:2], 2'h0};
      end
    end
  end

  // ****************************************
  // reads, one cycle after the strobe
  // ****************************************
  always @* begin
    next_rdata = 8'h00;
    if (rsvd_hit) begin
      next_rdata = reserved_cfg[rsvd_idx];
    end else begin
      case (reg_addr_in)
        `LRS_OFS_IDENT:    next_rdata = `LRS_IDENT_VALUE;
        `LRS_OFS_OVERRIDE: next_rdata = pin_override_control;
        `LRS_OFS_ROUTE:    next_rdata = route_select_control;
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  // ****************************************
  // effective selection: register or pin
  // ****************************************
  reg  [1:0] eff_sel [0:1];
  reg  [1:0] eff_mode;

  always @* begin
    eff_sel[1] = pin_override_control[`LRS_OVR_LANE1_BIT] ?       // [RULE1] [RULE12]
                 route_select_control[`LRS_LANE1_HI:`LRS_LANE1_LO] :
                 lane1_route_select_in;                           // [RULE4]
    eff_sel[0] = pin_override_control[`LRS_OVR_LANE0_BIT] ?       // [RULE2] [RULE12]
                 route_select_control[`LRS_LANE0_HI:`LRS_LANE0_LO] :
                 lane0_route_select_in;                           // [RULE4]
    eff_mode   = pin_override_control[`LRS_OVR_INEN_BIT] ?        // [RULE3] [RULE12]
                 route_select_control[`LRS_INEN_HI:`LRS_INEN_LO] :
                 input_enable_pin_in;                             // [RULE4]
  end

  // ****************************************
  // per-lane decode, registered onto the outputs
  // ****************************************
  wire [1:0] dec_in_a;
  wire [1:0] dec_in_b;
  wire [1:0] dec_out_a;
  wire [1:0] dec_out_b;
  wire [1:0] dec_term_a;
  wire [1:0] dec_term_b;

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
      lrs_lane_route u_lane (
        .sel_in       (eff_sel[gi]),
        .mode_in      (eff_mode),
        .rxdet_a_in   (rxdet_a_in[gi]),
        .rxdet_b_in   (rxdet_b_in[gi]),
        .input_a_out  (dec_in_a[gi]),
        .input_b_out  (dec_in_b[gi]),
        .output_a_out (dec_out_a[gi]),
        .output_b_out (dec_out_b[gi]),
        .term_a_out   (dec_term_a[gi]),
        .term_b_out   (dec_term_b[gi])
      );
    end
  endgenerate

  // outputs refresh every enabled clock so pin changes follow on the next enabled edge
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      input_a_en_out        <= 2'h0;
      input_b_en_out        <= 2'h0;
      output_a_en_out       <= 2'h0;
      output_b_en_out       <= 2'h0;
      term_a_en_out         <= 2'h0;
      term_b_en_out         <= 2'h0;
      dual_output_drive_out <= 1'b0;
      input_enable_mode_out <= 2'h0;
    end else if (clk_en_in) begin
      input_a_en_out        <= dec_in_a;                          // [RULE12]
      input_b_en_out        <= dec_in_b;
      output_a_en_out       <= dec_out_a;
      output_b_en_out       <= dec_out_b;
      term_a_en_out         <= dec_term_a;
      term_b_en_out         <= dec_term_b;
      dual_output_drive_out <= (eff_mode == `LRS_INEN_DUAL_OUTPUT_DRIVE);    // [RULE9]
      input_enable_mode_out <= eff_mode;
    end
  end
endmodule // lrs_route_regs

// ### verif/lrs_route_regs_asserts.sv
`timescale 1ns/10ps
// ****************************************
// routing and register checker
// ****************************************
module lrs_route_regs_asserts (
  input wire       core_clk_in,
  input wire       rst_in,
  input wire       clk_en_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_rvalid_out,
  input wire [1:0] lane1_route_select_in,
  input wire [1:0] lane0_route_select_in,
  input wire [1:0] input_enable_pin_in,
  input wire [1:0] rxdet_a_in,
  input wire [1:0] rxdet_b_in,
  input wire [1:0] input_a_en_out,
  input wire [1:0] input_b_en_out,
  input wire [1:0] output_a_en_out,
  input wire [1:0] output_b_en_out,
  input wire [1:0] term_a_en_out,
  input wire [1:0] term_b_en_out,
  input wire       dual_output_drive_out,
  input wire [1:0] input_enable_mode_out
);
  reg  [2:0] ovr_q;
  reg  [5:0] ctl_q;
  // shadow of the two control registers, only writable bits kept
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ovr_q <= 3'h0;
      ctl_q <= 6'h00;
    end else if (clk_en_in && reg_wr_in && reg_addr_in == 8'h5e) begin
      ovr_q <= reg_wdata_in[2:0];
    end else if (clk_en_in && reg_wr_in && reg_addr_in == 8'h5f) begin
      ctl_q <= reg_wdata_in[7:2];
    end
  end
  // per-lane enables: {in a, in b, out a, out b, term a, term b}
  function [5:0] lrs_exp(input [1:0] s, input [1:0] m, input ra, input rb);
    reg ia, ib;
    begin
      ia = s[1] & (m != 2'h2 || ra);
      ib = ~s[1] & (m != 2'h2 || rb);
      lrs_exp = {ia, ib, s[0] | (m == 2'h3), ~s[0] | (m == 2'h3), ia, ib};
    end
  endfunction
  wire [1:0] mode = ovr_q[0] ? ctl_q[1:0] : input_enable_pin_in;
  wire [1:0] lane1_route_select = ovr_q[2] ? ctl_q[5:4] : lane1_route_select_in;
  wire [1:0] lane0_route_select = ovr_q[1] ? ctl_q[3:2] : lane0_route_select_in;
  wire [5:0] exp1 = lrs_exp(lane1_route_select, mode, rxdet_a_in[1], rxdet_b_in[1]);
  wire [5:0] exp0 = lrs_exp(lane0_route_select, mode, rxdet_a_in[0], rxdet_b_in[0]);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  property p_mode; clk_en_in |=> input_enable_mode_out == $past(mode); endproperty
  a_mode: assert property (p_mode) else $error("mode mismatch");
  property p_fan; clk_en_in |=> dual_output_drive_out == ($past(mode) == 2'h3); endproperty
  a_fan: assert property (p_fan) else $error("fan-out mismatch");
  property p_lane1;
    clk_en_in |=> {input_a_en_out[1], input_b_en_out[1], output_a_en_out[1],
                   output_b_en_out[1], term_a_en_out[1], term_b_en_out[1]} == $past(exp1);
  endproperty
  a_lane1: assert property (p_lane1) else $error("lane 1 route");
  property p_lane0;
    clk_en_in |=> {input_a_en_out[0], input_b_en_out[0], output_a_en_out[0],
                   output_b_en_out[0], term_a_en_out[0], term_b_en_out[0]} == $past(exp0);
  endproperty
  a_lane0: assert property (p_lane0) else $error("lane 0 route");
  property p_term;
    clk_en_in && mode[1] == mode[0] |=> (term_a_en_out | term_b_en_out) == 2'h3;
  endproperty
  a_term: assert property (p_term) else $error("termination off");
  property p_auto;
    clk_en_in && mode == 2'h2 |=> !dual_output_drive_out &&
      (input_a_en_out & ~$past(rxdet_a_in)) == 2'h0;
  endproperty
  a_auto: assert property (p_auto) else $error("auto mode enable");
  property p_norm;
    clk_en_in && mode == 2'h0 |=> (output_a_en_out ^ output_b_en_out) == 2'h3 &&
      (input_a_en_out ^ input_b_en_out) == 2'h3;
  endproperty
  a_norm: assert property (p_norm) else $error("normal mode route");
  property p_ovr_rd;
    clk_en_in && reg_rd_in && reg_addr_in == 8'h5e |=>
      reg_rvalid_out && reg_rdata_out == {5'h00, $past(ovr_q)};
  endproperty
  a_ovr_rd: assert property (p_ovr_rd) else $error("override readback");
endmodule // lrs_route_regs_asserts

bind lrs_route_regs lrs_route_regs_asserts u_chk (.core_clk_in, .rst_in, .clk_en_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out,
  .lane1_route_select_in, .lane0_route_select_in, .input_enable_pin_in, .rxdet_a_in,
  .rxdet_b_in, .input_a_en_out, .input_b_en_out, .output_a_en_out, .output_b_en_out,
  .term_a_en_out, .term_b_en_out, .dual_output_drive_out, .input_enable_mode_out);

// ### verif/lane_route_select_override_test.sv
`timescale 1ns/10ps
// ****************************************
// bench for the route register block
// ****************************************
module lane_route_select_override_test;
  reg        core_clk_in, rst_in, clk_en_in, reg_wr_in, reg_rd_in;
  reg  [7:0] reg_addr_in, reg_wdata_in;
  reg  [1:0] lane1_route_select_in, lane0_route_select_in, input_enable_pin_in;
  reg  [1:0] rxdet_a_in, rxdet_b_in;
  wire [7:0] reg_rdata_out;
  wire       reg_rvalid_out, dual_output_drive_out;
  wire [1:0] input_a_en_out, input_b_en_out, output_a_en_out, output_b_en_out;
  wire [1:0] term_a_en_out, term_b_en_out, input_enable_mode_out;
  integer    miscompares, compares, cycles, seed, i;
  reg  [31:0] r;
  reg  [2:0] ovr;
  reg  [5:0] ctl;
  wire [15:0] seen_out = {1'b0, input_a_en_out, input_b_en_out, output_a_en_out, output_b_en_out,
                          term_a_en_out, term_b_en_out, dual_output_drive_out,
                          input_enable_mode_out};
  lrs_route_regs u_dut (.core_clk_in, .rst_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .lane1_route_select_in,
    .lane0_route_select_in, .input_enable_pin_in, .rxdet_a_in, .rxdet_b_in, .input_a_en_out,
    .input_b_en_out, .output_a_en_out, .output_b_en_out, .term_a_en_out, .term_b_en_out,
    .dual_output_drive_out, .input_enable_mode_out);
  // 200 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  function [7:0] reset_of(input [7:0] a);
    case (a)
      8'h51: reset_of = 8'h5a; // arbitrary identification value
      8'h56: reset_of = 8'h10;
      8'h57: reset_of = 8'h64;
      8'h58: reset_of = 8'h21;
      8'h5a, 8'h5b: reset_of = 8'h54;
      default: reset_of = 8'h00;
    endcase
  endfunction
  function [5:0] lane(input [1:0] s, input [1:0] m, input ra, input rb);
    reg ia, ib;
    begin
      ia = s[1] & (m != 2'h2 || ra);
      ib = ~s[1] & (m != 2'h2 || rb);
      lane = {ia, ib, s[0] | (m == 2'h3), ~s[0] | (m == 2'h3), ia, ib};
    end
  endfunction
  // expected outputs from bench shadow registers and pins
  function automatic [15:0] expect_out();
    reg [1:0] m;
    reg [5:0] e1, e0;
    begin
      m = ovr[0] ? ctl[1:0] : input_enable_pin_in;
      e1 = lane(ovr[2] ? ctl[5:4] : lane1_route_select_in, m, rxdet_a_in[1], rxdet_b_in[1]);
      e0 = lane(ovr[1] ? ctl[3:2] : lane0_route_select_in, m, rxdet_a_in[0], rxdet_b_in[0]);
      expect_out = {1'b0, e1[5], e0[5], e1[4], e0[4], e1[3], e0[3], e1[2], e0[2],
                    e1[1], e0[1], e1[0], e0[0], m == 2'h3, m};
    end
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge core_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge core_clk_in);
      reg_wr_in = 1'b0;
    end
  endtask
  // read strobe for one edge, data and valid checked one cycle on
  task rd_chk(input [7:0] a, input [7:0] exp);
    begin
      @(negedge core_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge core_clk_in);
      reg_rd_in = 1'b0;
      chk({7'h00, reg_rvalid_out, reg_rdata_out}, {8'h01, exp});
    end
  endtask
  // hang guard, generous against about 1600 cycles of work
  always @(posedge core_clk_in) begin
    cycles = cycles + 1;
    if (cycles > 6000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  initial begin
    seed = 4382; miscompares = 0; compares = 0; cycles = 0;
    rst_in = 1'b1; clk_en_in = 1'b1; reg_wr_in = 1'b0; reg_rd_in = 1'b0;
    reg_addr_in = 8'h00; reg_wdata_in = 8'h00; lane1_route_select_in = 2'h3;
    lane0_route_select_in = 2'h0; input_enable_pin_in = 2'h0;
    rxdet_a_in = 2'h0; rxdet_b_in = 2'h0; ovr = 3'h0; ctl = 6'h00;
    repeat (12) @(negedge core_clk_in);
    rst_in = 1'b0;
    @(negedge core_clk_in);
    chk(seen_out, expect_out());
    for (i = 8'h4c; i <= 8'h5f; i = i + 1) rd_chk(i[7:0], reset_of(i[7:0]));
    wr(8'h51, 8'hff);
    rd_chk(8'h51, 8'h5a);
    wr(8'h57, 8'ha5);
    rd_chk(8'h57, 8'ha5);
    wr(8'h5e, 8'hff);
    rd_chk(8'h5e, 8'h07);
    wr(8'h5f, 8'hff);
    rd_chk(8'h5f, 8'hfc);
    ovr = 3'h7; ctl = 6'h3f;
    chk(seen_out, expect_out());
    // clock enable low: write is dropped and outputs hold
    clk_en_in = 1'b0;
    wr(8'h5e, 8'h00);
    chk(seen_out, expect_out());
    clk_en_in = 1'b1;
    // the dropped write must not have cleared the overrides
    rd_chk(8'h5e, 8'h07);
    // random overrides, control values, pins and receiver detects
    for (i = 0; i < 300; i = i + 1) begin
      r = $random(seed);
      ovr = r[2:0];
      ctl = r[10:5];
      if (ctl[1:0] == 2'h1) ctl[1:0] = 2'h0; // reserved code kept out
      wr(8'h5e, {5'h00, ovr});
      wr(8'h5f, {ctl, 2'h0});
      {lane1_route_select_in, lane0_route_select_in, input_enable_pin_in} = r[16:11];
      {rxdet_a_in, rxdet_b_in} = r[20:17];
      if (input_enable_pin_in == 2'h1) input_enable_pin_in = 2'h0;
      @(negedge core_clk_in);
      chk(seen_out, expect_out());
    end
    // mid-run reset: outputs clear, registers return to reset, pins take over
    rst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk(seen_out, 16'h0000);
    rst_in = 1'b0;
    ovr = 3'h0;
    ctl = 6'h00;
    @(negedge core_clk_in);
    chk(seen_out, expect_out());
    rd_chk(8'h5e, 8'h00);
    rd_chk(8'h5f, 8'h00);
    rd_chk(8'h57, 8'h64);
    finish_test;
  end
endmodule // lane_route_select_override_test
